// [shared/ufwd_map.vh]
// Register map and timing constants of the unknown-frame forward control block
`ifndef UFWD_MAP_VH
`define UFWD_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UFWD_ADDR_UCAST      8'h83
`define UFWD_ADDR_MCAST      8'h84
`define UFWD_ADDR_VLAN       8'h85
`define UFWD_ADDR_IPMC       8'h86
`define UFWD_ADDR_RATE       8'h87

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UFWD_EN_BIT          5
`define UFWD_SELF_BIT        6
`define UFWD_MAP_MSB         4
`define UFWD_MAP_RSV_BIT     3
`define UFWD_PER_MSB         5
`define UFWD_PER_LSB         4

// ----------------------------------------
// Reset, reserved and period select values
// ----------------------------------------
`define UFWD_RSV_UCAST       2'h2
`define UFWD_RSV_MCAST       2'h1
`define UFWD_RSV_VLAN        2'h0
`define UFWD_RSV_IPMC        1'h0
`define UFWD_RATE_RST        2'h1
`define UFWD_MAP_RST         5'h00
`define UFWD_PER_16          2'h0
`define UFWD_PER_64          2'h1

// ----------------------------------------
// Timing: period in ms, clock in kHz
// ----------------------------------------
`define UFWD_T16_MS          16
`define UFWD_T64_MS          64
`define UFWD_T256_MS         256
`define UFWD_CLK_KHZ         100000

`endif

// [test/tb.sv]
// Self-checking testbench for the unknown-frame forward control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int          C16 = 20, C64 = 40, C256 = 80;
    localparam logic [47:0] MAC = 48'h0A0B0C0D0E0F;
    localparam logic [4:0]  DFLT = 5'h0A;
    logic        i_sys_clk, i_resetn, i_wr, i_rd, i_lk_valid, i_eg_valid;
    logic [7:0]  i_addr, i_wdata, o_rdata;
    logic [3:0]  miss;
    logic [47:0] i_eg_dst_mac, i_station_mac;
    logic [4:0]  o_fw_map;
    logic [1:0]  o_rate_period;
    logic        o_fw_valid, o_fw_special, o_eg_discard, o_rate_tick;
    int          miscompares = 0, checked = 0, cycles = 0;

    ufwd_ctrl #(.CYC_16(C16), .CYC_64(C64), .CYC_256(C256)) DUT (.i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_lk_valid(i_lk_valid), .i_lk_ucast_miss(miss[0]),
        .i_lk_mcast_miss(miss[1]), .i_lk_vlan_miss(miss[2]), .i_lk_ipmc_miss(miss[3]),
        .i_lk_default_map(DFLT), .o_fw_valid(o_fw_valid), .o_fw_map(o_fw_map),
        .o_fw_special(o_fw_special), .i_eg_valid(i_eg_valid), .i_eg_dst_mac(i_eg_dst_mac),
        .i_station_mac(i_station_mac), .o_eg_discard(o_eg_discard),
        .o_rate_period(o_rate_period),
        .o_rate_tick(o_rate_tick));

    task automatic chk(input string what, input logic [7:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Write when w is set, else read and compare with d
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge i_sys_clk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1;
        if (!w) chk("rdata", d, o_rdata);
    endtask
    task automatic lk(input logic [3:0] m, input logic [4:0] map, input logic sp);
        @(posedge i_sys_clk);
        i_lk_valid <= 1'b1;
        miss <= m;
        @(posedge i_sys_clk);
        i_lk_valid <= 1'b0;
        #1 chk("fw", {1'b1, sp, 1'b0, map}, {o_fw_valid, o_fw_special, 1'b0, o_fw_map});
    endtask
    task automatic eg(input logic [47:0] dst, input logic exp);
        @(posedge i_sys_clk);
        i_eg_valid <= 1'b1;
        i_eg_dst_mac <= dst;
        @(posedge i_sys_clk);
        i_eg_valid <= 1'b0;
        #1 chk("discard", {7'h0, exp}, {7'h0, o_eg_discard});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] rst [6] = '{8'h80, 8'h40, 8'h00, 8'h00, 8'h10, 8'h00};
        for (int k = 0; k < 6; k++)
            bus(1'b0, 8'h83 + k[7:0], rst[k]);
        bus(1'b1, 8'h88, 8'hFF);
        bus(1'b0, 8'h88, 8'h00);
    endtask
    // Each class enabled then disabled; ends with all enabled
    task automatic t_class;
        logic [7:0] wd [4] = '{8'h37, 8'h2B, 8'h27, 8'h20};
        logic [7:0] rsv [4] = '{8'h80, 8'h40, 8'h00, 8'h00};
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 8'h83 + k[7:0], wd[k]);
            bus(1'b0, 8'h83 + k[7:0], rsv[k] | (wd[k] & 8'hF7));
            lk(4'h1 << k, wd[k][4:0] & 5'h17, 1'b1);
            bus(1'b1, 8'h83 + k[7:0], wd[k] & 8'hDF);
            lk(4'h1 << k, DFLT, 1'b0);
            bus(1'b1, 8'h83 + k[7:0], wd[k]);
        end
        lk(4'hF, 5'h07, 1'b1);
        lk(4'hB, 5'h00, 1'b1);
        lk(4'h3, 5'h03, 1'b1);
        lk(4'h0, DFLT, 1'b0);
    endtask
    task automatic t_self;
        bus(1'b1, 8'h86, 8'h60);
        eg(MAC, 1'b1);
        eg(MAC ^ 48'h1, 1'b0);
        // Station address is live, not a fixed value
        @(posedge i_sys_clk);
        i_station_mac <= ~MAC;
        eg(~MAC, 1'b1);
        eg(MAC, 1'b0);
        @(posedge i_sys_clk);
        i_station_mac <= MAC;
        bus(1'b1, 8'h86, 8'h20);
        eg(MAC, 1'b0);
    endtask
    // First pass only syncs to a tick; a rewrite may restart the window
    task automatic t_period;
        int lim [4] = '{C16, C64, C256, C256};
        int n;
        for (int v = 0; v < 4; v++)
        begin
            bus(1'b1, 8'h87, {2'h0, v[1:0], 4'h0});
            bus(1'b0, 8'h87, {2'h0, v[1:0], 4'h0});
            chk("period", {6'h0, v[1:0]}, {6'h0, o_rate_period});
            for (int p = 0; p < 2; p++)
            begin
                n = 0;
                do
                begin
                    @(posedge i_sys_clk);
                    #1 n++;
                end
                while (o_rate_tick !== 1'b1 && n < 300);
            end
            chk("tick_gap", lim[v][7:0], n[7:0]);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge i_sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end
    initial
    begin
        {i_resetn, i_wr, i_rd, i_lk_valid, i_eg_valid, miss, i_addr, i_wdata} = '0;
        i_eg_dst_mac = 48'h0;
        i_station_mac = MAC;
        repeat (20) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_class();
        t_self();
        t_period();
        complete_run();
    end
endmodule
`default_nettype wire

// [test/ufwd_chk.sv]
// Assertion checker for the unknown-frame forward control block
`timescale 1ns/10ps
`default_nettype none
module ufwd_chk
#(
    parameter CYC_16  = 20,
    parameter CYC_64  = 40,
    parameter CYC_256 = 80
)
(
    input wire logic        i_sys_clk,
    input wire logic        i_resetn,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        i_lk_valid,
    input wire logic        o_fw_valid,
    input wire logic        i_eg_valid,
    input wire logic [47:0] i_eg_dst_mac,
    input wire logic [47:0] i_station_mac,
    input wire logic        o_eg_discard,
    input wire logic [1:0]  o_rate_period,
    input wire logic        o_rate_tick
);
    // ----------------------------------------
    // Filter enable mirror, cycles since tick
    // ----------------------------------------
    logic        self_en;
    logic        rewind;
    logic [31:0] gap;
    logic [31:0] lim;
    assign lim = o_rate_period[1] ? CYC_256 : (o_rate_period[0] ? CYC_64 : CYC_16);
    always @(posedge i_sys_clk)
    begin
        self_en <= !i_resetn ? 1'b0 : (i_wr && i_addr == 8'h86) ? i_wdata[6] : self_en;
        gap <= (!i_resetn || o_rate_tick) ? 32'h0 : gap + 32'h1;
        // A period rewrite may cut the running window short, so its end is not timed
        rewind <= (!i_resetn || (i_wr && i_addr == 8'h87)) ? 1'b1 : (o_rate_tick ? 1'b0 : rewind);
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    chk_map_rsv:
    assert property (i_rd && i_addr >= 8'h83 && i_addr <= 8'h86 |=> !o_rdata[3])
        else $error("map bit 3 read back set");
    chk_rate_read:
    assert property (i_rd && i_addr == 8'h87 |=> o_rdata == {2'h0, $past(o_rate_period), 4'h0})
        else $error("period read back wrong");
    chk_rate_write:
    assert property (i_wr && i_addr == 8'h87 |=> o_rate_period == $past(i_wdata[5:4]))
        else $error("period write not taken");
    chk_rate_reset:
    assert property ($rose(i_resetn) |-> o_rate_period == 2'h1)
        else $error("period reset value wrong");
    chk_fw_answer:
    assert property (i_lk_valid |=> o_fw_valid)
        else $error("lookup not answered");
    chk_self_on:
    assert property (i_eg_valid && self_en && i_eg_dst_mac == i_station_mac |=> o_eg_discard)
        else $error("own address not discarded");
    chk_self_off:
    assert property (i_eg_valid && !self_en |=> !o_eg_discard)
        else $error("discard while filter off");
    chk_tick_min:
    assert property (o_rate_tick && !rewind |-> gap == lim - 32'h1)
        else $error("period tick spacing wrong");
endmodule

bind ufwd_ctrl ufwd_chk #(.CYC_16(CYC_16), .CYC_64(CYC_64), .CYC_256(CYC_256)) u_chk (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_lk_valid(i_lk_valid), .o_fw_valid(o_fw_valid), .i_eg_valid(i_eg_valid),
    .i_eg_dst_mac(i_eg_dst_mac), .i_station_mac(i_station_mac), .o_eg_discard(o_eg_discard),
    .o_rate_period(o_rate_period), .o_rate_tick(o_rate_tick));
`default_nettype wire

// [verilog/ufwd_ctrl.v]
// Unknown-frame forwarding control registers and decision logic
`timescale 1ns/10ps
`default_nettype none
`include "ufwd_map.vh"

module ufwd_ctrl
#(
    parameter PORTS   = 5,
    parameter CYC_16  = `UFWD_T16_MS * `UFWD_CLK_KHZ,
    parameter CYC_64  = `UFWD_T64_MS * `UFWD_CLK_KHZ,
    parameter CYC_256 = `UFWD_T256_MS * `UFWD_CLK_KHZ
)
(
    // Clock and reset
    input  wire             i_sys_clk,
    input  wire             i_resetn,
    // Register port
    input  wire [7:0]       i_addr,
    input  wire [7:0]       i_wdata,
    input  wire             i_wr,
    input  wire             i_rd,
    output reg  [7:0]       o_rdata,
    // Lookup request
    input  wire             i_lk_valid,
    input  wire             i_lk_ucast_miss,
    input  wire             i_lk_mcast_miss,
    input  wire             i_lk_vlan_miss,
    input  wire             i_lk_ipmc_miss,
    input  wire [PORTS-1:0] i_lk_default_map,
    // Lookup result
    output reg              o_fw_valid,
    output reg  [PORTS-1:0] o_fw_map,
    output reg              o_fw_special,
    // Egress self-address check
    input  wire             i_eg_valid,
    input  wire [47:0]      i_eg_dst_mac,
    input  wire [47:0]      i_station_mac,
    output reg              o_eg_discard,
    // Rate limit period
    output wire [1:0]       o_rate_period,
    output wire             o_rate_tick
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg              ucast_en;
    reg  [4:0]       ucast_map;
    reg              mcast_en;
    reg  [4:0]       mcast_map;
    reg              vlan_en;
    reg  [4:0]       vlan_map;
    reg              ipmc_en;
    reg  [4:0]       ipmc_map;
    reg              self_en;
    reg  [1:0]       rate_per;
    reg  [PORTS-1:0] next_map;
    reg              next_special;

    // Map with reserved bit forced clear; software must keep it zero
    function [4:0] ufwd_clean;
        input [7:0] d;
        begin
            ufwd_clean = d[`UFWD_MAP_MSB:0];
            ufwd_clean[`UFWD_MAP_RSV_BIT] = 1'b0;
        end
    endfunction

    // Widen a 5-bit map to the port count
    function [PORTS-1:0] ufwd_ports;
        input [4:0] m;
        integer k;
        begin
            ufwd_ports = {PORTS{1'b0}};
            for (k = 0; k < PORTS && k < 5; k = k + 1)
                ufwd_ports[k] = m[k];
        end
    endfunction

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge i_sys_clk)
    begin
        if (!i_resetn)
        begin
            ucast_en  <= 1'b0;
            ucast_map <= `UFWD_MAP_RST;
            mcast_en  <= 1'b0;
            mcast_map <= `UFWD_MAP_RST;
            vlan_en   <= 1'b0;
            vlan_map  <= `UFWD_MAP_RST;
            ipmc_en   <= 1'b0;
            ipmc_map  <= `UFWD_MAP_RST;
            self_en   <= 1'b0;
            rate_per  <= `UFWD_RATE_RST;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `UFWD_ADDR_UCAST:
                begin
                    ucast_en  <= i_wdata[`UFWD_EN_BIT];
                    ucast_map <= ufwd_clean(i_wdata);
                end
                `UFWD_ADDR_MCAST:
                begin
                    mcast_en  <= i_wdata[`UFWD_EN_BIT];
                    mcast_map <= ufwd_clean(i_wdata);
                end
                `UFWD_ADDR_VLAN:
                begin
                    vlan_en  <= i_wdata[`UFWD_EN_BIT];
                    vlan_map <= ufwd_clean(i_wdata);
                end
                `UFWD_ADDR_IPMC:
                begin
                    self_en  <= i_wdata[`UFWD_SELF_BIT];
                    ipmc_en  <= i_wdata[`UFWD_EN_BIT];
                    ipmc_map <= ufwd_clean(i_wdata);
                end
                `UFWD_ADDR_RATE:
                    rate_per <= i_wdata[`UFWD_PER_MSB:`UFWD_PER_LSB];
                default:
                    ;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads, data one cycle later
    // ----------------------------------------
    always @(posedge i_sys_clk)
    begin
        if (!i_resetn)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `UFWD_ADDR_UCAST: o_rdata <= {`UFWD_RSV_UCAST, ucast_en, ucast_map};
                `UFWD_ADDR_MCAST: o_rdata <= {`UFWD_RSV_MCAST, mcast_en, mcast_map};
                `UFWD_ADDR_VLAN:  o_rdata <= {`UFWD_RSV_VLAN, vlan_en, vlan_map};
                `UFWD_ADDR_IPMC:  o_rdata <= {`UFWD_RSV_IPMC, self_en, ipmc_en, ipmc_map};
                `UFWD_ADDR_RATE:  o_rdata <= {2'h0, rate_per, 4'h0};
                default:          o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

    // ----------------------------------------
    // Forwarding decision
    // ----------------------------------------
    // VLAN miss checked first: an unknown VID frame has no valid table at all
    always @*
    begin
        next_map     = i_lk_default_map;
        next_special = 1'b0;
        if (i_lk_vlan_miss && vlan_en)
        begin
            next_map     = ufwd_ports(vlan_map);
            next_special = 1'b1;
        end
        else if (i_lk_ipmc_miss && ipmc_en)
        begin
            next_map     = ufwd_ports(ipmc_map);
            next_special = 1'b1;
        end
        else if (i_lk_mcast_miss && !i_lk_ipmc_miss && mcast_en)
        begin
            next_map     = ufwd_ports(mcast_map);
            next_special = 1'b1;
        end
        else if (i_lk_ucast_miss && ucast_en)
        begin
            next_map     = ufwd_ports(ucast_map);
            next_special = 1'b1;
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (!i_resetn)
        begin
            o_fw_valid   <= 1'b0;
            o_fw_map     <= {PORTS{1'b0}};
            o_fw_special <= 1'b0;
            o_eg_discard <= 1'b0;
        end
        else
        begin
            o_fw_valid   <= i_lk_valid;
            o_fw_map     <= i_lk_valid ? next_map : {PORTS{1'b0}};
            o_fw_special <= i_lk_valid & next_special;
            // Egress compare against own station address
            o_eg_discard <= i_eg_valid & self_en &
                            (i_eg_dst_mac == i_station_mac);
        end
    end

    // ----------------------------------------
    // Rate limit period
    // ----------------------------------------
    assign o_rate_period = rate_per;

    ufwd_period_tick
    #(
        .CNT_W   (25),
        .CYC_16  (CYC_16),
        .CYC_64  (CYC_64),
        .CYC_256 (CYC_256)
    )
    u_tick
    (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_sel     (rate_per),
        .o_tick    (o_rate_tick)
    );

endmodule
`default_nettype wire

// [verilog/ufwd_period_tick.v]
// Ingress rate limit period tick generator
`timescale 1ns/10ps
`default_nettype none
`include "ufwd_map.vh"

module ufwd_period_tick
#(
    parameter CNT_W    = 25,
    parameter CYC_16   = `UFWD_T16_MS * `UFWD_CLK_KHZ,
    parameter CYC_64   = `UFWD_T64_MS * `UFWD_CLK_KHZ,
    parameter CYC_256  = `UFWD_T256_MS * `UFWD_CLK_KHZ
)
(
    // Clock and reset
    input  wire             i_sys_clk,
    input  wire             i_resetn,
    // Period select
    input  wire [1:0]       i_sel,
    // Tick out
    output reg              o_tick
);

    reg  [CNT_W-1:0] count;
    wire [CNT_W-1:0] limit;

    // ----------------------------------------
    // Window length select
    // ----------------------------------------
    // Upper bit set means longest window regardless of low bit
    assign limit = i_sel[1] ? CYC_256[CNT_W-1:0] :
                   (i_sel[0] ? CYC_64[CNT_W-1:0] : CYC_16[CNT_W-1:0]);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always @(posedge i_sys_clk)
    begin
        if (!i_resetn)
        begin
            count  <= {CNT_W{1'b0}};
            o_tick <= 1'b0;
        end
        // A window shortened to or below the current count restarts at once
        else if (count >= limit - 1'b1)
        begin
            count  <= {CNT_W{1'b0}};
            o_tick <= 1'b1;
        end
        else
        begin
            count  <= count + 1'b1;
            o_tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire
